// >>> asp_pkg.sv
package asp_pkg;

  // ****************************************************************
  // Register map (APB byte addresses, one aligned word each).
  // ****************************************************************
  localparam logic [7:0] ASP_SERIAL_DATA_PORT_OFS = 8'h23;
  localparam logic [7:0] ASP_SERIAL_DATA_PORT_IDX = 8'h23;
  localparam logic [11:0] ASP_ADDR_DATA = 12'h08C;
  localparam logic [11:0] ASP_ADDR_CTRL = 12'h090;
  localparam logic [11:0] ASP_ADDR_TIMER = 12'h094;
  localparam logic [11:0] ASP_ADDR_TFLAG = 12'h098;

  // ****************************************************************
  // Control/status field positions and reset values.
  // ****************************************************************
  localparam int ASP_TX_ENABLE_BIT = 0;
  localparam int ASP_TX_IRQ_SOURCE_SELECT = 1;
  localparam int ASP_DATA_WIDTH_SELECT = 2;
  localparam int ASP_PARITY_ENABLE_BIT = 3;
  localparam int ASP_PARITY_SENSE_SELECT = 4;
  localparam int ASP_RX_ENABLE_BIT = 5;
  localparam int ASP_SEMAPHORE_BIT = 6;
  localparam int ASP_RX_ERROR_FLAG = 7;
  localparam logic [7:0] ASP_CTRL_RESET = 8'h00;
  localparam logic [15:0] ASP_TIMER_RESET = 16'hFFFF;

  // ****************************************************************
  // Timing counts.
  // ****************************************************************
  localparam logic [3:0] ASP_OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] ASP_HALF_BIT_TICKS = 4'h7;

  // Receiver states.
  typedef enum logic [3:0] {
    ASP_RX_IDLE = 4'b0001,
    ASP_RX_START = 4'b0010,
    ASP_RX_DATA = 4'b0100,
    ASP_RX_STOP = 4'b1000
  } asp_rx_state_t;

  // Control/status register contents.
  typedef struct packed {
    logic rx_error_flag;
    logic semaphore;
    logic rx_enable_bit;
    logic parity_sense_select;
    logic parity_enable;
    logic data_width_select;
    logic tx_irq_source_select;
    logic tx_enable_bit;
  } asp_ctrl_t;

endpackage

// >>> asp_baud_timer.sv
`timescale 1ns/1ps
// Reloadable interval timer; forced to auto-reload while the port runs.
module asp_baud_timer
  import asp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire logic i_load,
  input wire logic [15:0] i_reload,
  output logic o_tick
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // Count down to zero and reload; each underflow is one oversample tick.
  always_comb begin
    o_tick = 1'b0;
    cnt_d = cnt_q;
    if (i_load || !i_run) begin
      cnt_d = i_reload;
    end else if (cnt_q == 16'h0000) begin
      cnt_d = i_reload; // [RULE2]
      o_tick = 1'b1;
    end else begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= ASP_TIMER_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // asp_baud_timer

// >>> asp_uart.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
// Function
// (RULE1) Bits run at one sixteenth of the timer underflow rate.
// (RULE2) Timer auto-reloads whenever either direction is enabled.
// (RULE3) Software loads the timer before enabling the port.
// (RULE4) Software loads reload code clock/(16*rate) minus one.
// (RULE5) Transmitter and receiver have separate enables.
// (RULE6) Seven or eight data bits, parity none, odd or even.
// (RULE7) Transmit one stop bit with parity, two without.
// (RULE8) Receiver checks only the first stop bit.
// (RULE9) Transmitter adds start, parity and stop bits itself.
// (RULE10) One address writes transmit holding, reads receive holding.
// (RULE11) Tx interrupt gated by enable; source select picks empty condition.
// (RULE12) Receiver and its status work only while receive enable set.
// (RULE13) Sixteen ticks per bit, aligned to start edge, mid-bit sample.
// (RULE14) Start shorter than half a bit is noise and abandoned.
// (RULE15) Error flag set on parity, framing or overrun.
// (RULE16) Overrun when a new byte lands before the old one is read.
// (RULE17) Rx interrupt on each shift-to-holding transfer.
// (RULE18) Timer edge flag never set while port runs; write one clears.
// (RULE19) Tx interrupt cleared by data write or reset.
// (RULE20) Seven-bit mode drops written bit 7, reads bit 7 as zero.
// (RULE21) Parity sense zero gives odd, one gives even.
// (RULE22) Error flag cleared by reset or write of one.
// (RULE23) Line idles high, LSB first, parity after data.
module asp_uart
  import asp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_timer_edge,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_tx_interrupt,
  output logic o_rx_interrupt
);

  // ****************************************************************
  // Register bus.
  // ****************************************************************
  logic acc;
  logic wr;
  logic rd;
  logic hit_data;
  logic hit_ctrl;
  logic hit_timer;
  logic hit_tflag;
  asp_ctrl_t ctrl_q;
  asp_ctrl_t ctrl_d;
  logic [15:0] reload_q;
  logic [15:0] reload_d;
  logic tflag_q;
  logic tflag_d;
  logic [7:0] thr_q;
  logic [7:0] thr_d;
  logic thr_full_q;
  logic thr_full_d;
  logic [7:0] rhr_q;
  logic [7:0] rhr_d;
  logic rhr_full_q;
  logic rhr_full_d;
  logic tx_irq_q;
  logic tx_irq_d;
  logic rx_irq_q;
  logic rx_irq_d;
  logic tick;
  logic port_run;
  logic rx_load;
  logic [7:0] rx_byte;
  logic rx_err;

  // Zero-wait slave: every access completes in its first access cycle.
  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite;
  assign rd = acc && !i_pwrite;
  assign hit_data = (i_paddr == ASP_ADDR_DATA);
  assign hit_ctrl = (i_paddr == ASP_ADDR_CTRL);
  assign hit_timer = (i_paddr == ASP_ADDR_TIMER);
  assign hit_tflag = (i_paddr == ASP_ADDR_TFLAG);
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !(hit_data || hit_ctrl || hit_timer || hit_tflag);
  assign port_run = ctrl_q.tx_enable_bit || ctrl_q.rx_enable_bit;

  // Read mux; the data word is the receive holding register.
  always_comb begin
    o_prdata = 32'h0000_0000;
    if (hit_data) begin
      o_prdata = {24'h00_0000,
        ctrl_q.data_width_select ? rhr_q : {1'b0, rhr_q[6:0]}}; // [RULE10] [RULE20]
    end else if (hit_ctrl) begin
      o_prdata = {24'h00_0000, ctrl_q};
    end else if (hit_timer) begin
      o_prdata = {16'h0000, reload_q};
    end else if (hit_tflag) begin
      o_prdata = {31'h0000_0000, tflag_q};
    end
  end

  // ****************************************************************
  // Baud timer and sixteen-tick bit clock.
  // ****************************************************************
  asp_baud_timer u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(port_run), // [RULE2]
    .i_load(wr && hit_timer),
    .i_reload(reload_q),
    .o_tick(tick)
  );

  // ****************************************************************
  // Transmitter.
  // ****************************************************************
  logic [10:0] tsh_q;
  logic [10:0] tsh_d;
  logic [3:0] tbits_q;
  logic [3:0] tbits_d;
  logic [3:0] tdiv_q;
  logic [3:0] tdiv_d;
  logic [3:0] nbits;
  logic tpar;
  logic [7:0] tdata;

  // Frame length: start + data + parity-or-extra-stop + stop.
  assign nbits = ctrl_q.data_width_select ? 4'hB : 4'hA; // [RULE6] [RULE7]
  assign tdata = ctrl_q.data_width_select ? thr_q : {1'b0, thr_q[6:0]};
  assign tpar = ^tdata ^ ~ctrl_q.parity_sense_select; // [RULE21]

  // Shift one bit out per sixteen ticks, LSB first after a low start bit.
  always_comb begin
    tsh_d = tsh_q;
    tbits_d = tbits_q;
    tdiv_d = tdiv_q;
    thr_full_d = thr_full_q;
    thr_d = thr_q;
    if (!ctrl_q.tx_enable_bit) begin // [RULE5]
      tbits_d = 4'h0;
      tdiv_d = 4'h0;
      tsh_d = 11'h7FF;
    end else if (tbits_q == 4'h0) begin
      // Start only on a tick, so the start bit lasts a full sixteen ticks.
      if (thr_full_q && tick) begin // [RULE1]
        thr_full_d = 1'b0;
        tbits_d = nbits;
        tdiv_d = 4'h0;
        if (ctrl_q.data_width_select) begin
          tsh_d = {1'b1, ctrl_q.parity_enable ? tpar : 1'b1, tdata, 1'b0}; // [RULE9]
        end else begin
          tsh_d = {2'b11, ctrl_q.parity_enable ? tpar : 1'b1, tdata[6:0], 1'b0}; // [RULE23]
        end
      end
    end else if (tick) begin
      tdiv_d = tdiv_q + 4'h1;
      if (tdiv_q == ASP_OVERSAMPLE_LAST) begin
        tsh_d = {1'b1, tsh_q[10:1]}; // [RULE1]
        tbits_d = tbits_q - 4'h1;
      end
    end
    if (wr && hit_data) begin
      thr_d = ctrl_q.data_width_select ? i_pwdata[7:0] : {1'b0, i_pwdata[6:0]}; // [RULE20]
      thr_full_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tsh_q <= 11'h7FF;
      tbits_q <= 4'h0;
      tdiv_q <= 4'h0;
      thr_q <= 8'h00;
      thr_full_q <= 1'b0;
    end else begin
      tsh_q <= tsh_d;
      tbits_q <= tbits_d;
      tdiv_q <= tdiv_d;
      thr_q <= thr_d;
      thr_full_q <= thr_full_d;
    end
  end

  assign o_txd = tsh_q[0];

  // ****************************************************************
  // Receiver.
  // ****************************************************************
  asp_rx_state_t rst_q;
  asp_rx_state_t rst_d;
  logic [3:0] rdiv_q;
  logic [3:0] rdiv_d;
  logic [3:0] rcnt_q;
  logic [3:0] rcnt_d;
  logic [8:0] rsh_q;
  logic [8:0] rsh_d;
  logic [3:0] rlen;
  logic [7:0] rdat;
  logic rpar_bad;

  // Data plus optional parity bits to gather after the start bit.
  assign rlen = 4'h7 + {3'h0, ctrl_q.data_width_select} + {3'h0, ctrl_q.parity_enable};
  assign rdat = ctrl_q.data_width_select
    ? (ctrl_q.parity_enable ? rsh_q[7:0] : rsh_q[8:1])
    : {1'b0, ctrl_q.parity_enable ? rsh_q[7:1] : rsh_q[8:2]};
  assign rpar_bad = ctrl_q.parity_enable
    && ((^rdat ^ rsh_q[8]) != ~ctrl_q.parity_sense_select); // [RULE21]

  // Sample mid-bit: half a bit after the edge, then every sixteen ticks.
  always_comb begin
    rst_d = rst_q;
    rdiv_d = rdiv_q;
    rcnt_d = rcnt_q;
    rsh_d = rsh_q;
    rx_load = 1'b0;
    rx_byte = rdat;
    rx_err = 1'b0;
    case (rst_q)
      ASP_RX_IDLE: begin
        rdiv_d = 4'h0;
        if (tick && !i_rxd) begin
          rst_d = ASP_RX_START; // [RULE13]
        end
      end
      ASP_RX_START: begin
        if (tick) begin
          if (i_rxd) begin
            rst_d = ASP_RX_IDLE; // [RULE14]
          end else if (rdiv_q == ASP_HALF_BIT_TICKS) begin
            rdiv_d = 4'h0;
            rcnt_d = 4'h0;
            rst_d = ASP_RX_DATA;
          end else begin
            rdiv_d = rdiv_q + 4'h1;
          end
        end
      end
      ASP_RX_DATA: begin
        if (tick) begin
          rdiv_d = rdiv_q + 4'h1;
          if (rdiv_q == ASP_OVERSAMPLE_LAST) begin
            rsh_d = {i_rxd, rsh_q[8:1]}; // [RULE13] [RULE23]
            rcnt_d = rcnt_q + 4'h1;
            if (rcnt_q + 4'h1 == rlen) begin
              rst_d = ASP_RX_STOP;
            end
          end
        end
      end
      ASP_RX_STOP: begin
        if (tick) begin
          rdiv_d = rdiv_q + 4'h1;
          if (rdiv_q == ASP_OVERSAMPLE_LAST) begin
            // Short frames stay left-justified; the data decode allows for it.
            rsh_d = rsh_q;
            rx_load = 1'b1; // [RULE8] [RULE17]
            rx_err = !i_rxd || rpar_bad || rhr_full_q; // [RULE15] [RULE16]
            rst_d = ASP_RX_IDLE;
          end
        end
      end
      default: begin
        rst_d = ASP_RX_IDLE;
      end
    endcase
    if (!ctrl_q.rx_enable_bit) begin
      rst_d = ASP_RX_IDLE; // [RULE12]
      rx_load = 1'b0;
      rx_err = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rst_q <= ASP_RX_IDLE;
      rdiv_q <= 4'h0;
      rcnt_q <= 4'h0;
      rsh_q <= 9'h000;
    end else begin
      rst_q <= rst_d;
      rdiv_q <= rdiv_d;
      rcnt_q <= rcnt_d;
      rsh_q <= rsh_d;
    end
  end

  // ****************************************************************
  // Control, holding registers and interrupts.
  // ****************************************************************
  // New events win over software clears in the same cycle, except the tx interrupt, where a data write wins.
  always_comb begin
    ctrl_d = ctrl_q;
    reload_d = reload_q;
    tflag_d = tflag_q;
    rhr_d = rhr_q;
    rhr_full_d = rhr_full_q;
    rx_irq_d = rx_irq_q;
    if (wr && hit_ctrl) begin
      ctrl_d = asp_ctrl_t'({1'b0, i_pwdata[6:0]});
      ctrl_d.rx_error_flag = ctrl_q.rx_error_flag && !i_pwdata[ASP_RX_ERROR_FLAG]; // [RULE22]
      if (!i_pwdata[ASP_TX_ENABLE_BIT]) begin
        ctrl_d.tx_irq_source_select = 1'b0;
      end
    end
    if (wr && hit_timer) begin
      reload_d = i_pwdata[15:0];
    end
    if (wr && hit_tflag && i_pwdata[0]) begin
      tflag_d = 1'b0; // [RULE18]
    end
    if (i_timer_edge && !port_run) begin
      tflag_d = 1'b1; // [RULE18]
    end
    if (rd && hit_data) begin
      rhr_full_d = 1'b0;
      rx_irq_d = 1'b0;
    end
    if (!ctrl_q.rx_enable_bit) begin
      rhr_d[7] = 1'b0;
      rhr_full_d = 1'b0;
      rx_irq_d = 1'b0;
    end
    if (rx_load) begin
      rhr_d = rx_byte; // [RULE20]
      rhr_full_d = 1'b1;
      rx_irq_d = 1'b1; // [RULE17]
    end
    if (rx_err) begin
      ctrl_d.rx_error_flag = 1'b1; // [RULE15]
    end
  end

  // Tx interrupt: holding empty, or holding and shift empty, while enabled.
  always_comb begin
    tx_irq_d = tx_irq_q;
    if (wr && hit_data) begin
      tx_irq_d = 1'b0; // [RULE19]
    end else if (ctrl_q.tx_enable_bit && !thr_full_q
        && (!ctrl_q.tx_irq_source_select || tbits_q == 4'h0)) begin
      tx_irq_d = 1'b1; // [RULE11]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= asp_ctrl_t'(ASP_CTRL_RESET);
      reload_q <= ASP_TIMER_RESET;
      tflag_q <= 1'b0;
      rhr_q <= 8'h00;
      rhr_full_q <= 1'b0;
      rx_irq_q <= 1'b0;
      tx_irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      reload_q <= reload_d;
      tflag_q <= tflag_d;
      rhr_q <= rhr_d;
      rhr_full_q <= rhr_full_d;
      rx_irq_q <= rx_irq_d;
      tx_irq_q <= tx_irq_d;
    end
  end

  assign o_tx_interrupt = tx_irq_q && ctrl_q.tx_enable_bit; // [RULE11]
  assign o_rx_interrupt = rx_irq_q;

endmodule // asp_uart

// >>> asp_uart_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checks on the serial port block.
// ****************************************************************
module asp_uart_chk
  import asp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_timer_edge,
  input wire logic i_rxd,
  input wire logic o_txd,
  input wire logic o_tx_interrupt,
  input wire logic o_rx_interrupt
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic acc, wr, rd, mapped;
  logic [7:0] ctrl_q;
  logic [15:0] rld_q;
  int low_q;
  // Transfer strobes; pready is part of the term so a stalled slave is not miscounted.
  assign acc = i_psel && i_penable && o_pready;
  assign wr = acc && i_pwrite;
  assign rd = acc && !i_pwrite;
  assign mapped = i_paddr inside {ASP_ADDR_DATA, ASP_ADDR_CTRL, ASP_ADDR_TIMER, ASP_ADDR_TFLAG};
  // Shadow copies of control and reload, and the length of each low run on the line.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= ASP_CTRL_RESET;
      rld_q <= ASP_TIMER_RESET;
      low_q <= 0;
    end else begin
      if (wr && i_paddr == ASP_ADDR_CTRL) begin
        ctrl_q <= {i_pwdata[7:2], i_pwdata[1] & i_pwdata[0], i_pwdata[0]};
      end
      if (wr && i_paddr == ASP_ADDR_TIMER) begin
        rld_q <= i_pwdata[15:0];
      end
      low_q <= o_txd ? 0 : low_q + 1;
    end
  end
  pready_now_a: assert property (i_psel && i_penable |-> o_pready)
    else $error("pready low in access phase");
  slverr_map_a: assert property (acc |-> o_pslverr == !mapped)
    else $error("pslverr disagrees with address map");
  reset_idle_a: assert property ($fell(i_sys_rst) |-> o_txd && !o_tx_interrupt && !o_rx_interrupt)
    else $error("outputs not idle after reset");
  bit_length_a: assert property ($rose(o_txd) |-> low_q % (16 * (int'(rld_q) + 1)) == 0)
    else $error("low run not a whole number of bit times");
  start_bit_a: assert property ($fell(o_txd) |-> ctrl_q[0] ##1 !o_txd [*7])
    else $error("start bit without enable or too short");
  tx_gate_a: assert property (!ctrl_q[0] && !$past(ctrl_q[0]) |-> !o_tx_interrupt)
    else $error("tx interrupt while transmitter disabled");
  tx_clear_a: assert property (wr && i_paddr == ASP_ADDR_DATA |=> !o_tx_interrupt)
    else $error("tx interrupt not cleared by data write");
  rx_gate_a: assert property (!ctrl_q[5] && !$past(ctrl_q[5]) |-> !o_rx_interrupt)
    else $error("rx interrupt while receiver disabled");
  read_seven_a: assert property (rd && i_paddr == ASP_ADDR_DATA && !ctrl_q[2] |-> !o_prdata[7])
    else $error("bit 7 set in seven bit read");
  ctrl_read_a: assert property (rd && i_paddr == ASP_ADDR_CTRL |-> o_prdata[6:0] == ctrl_q[6:0])
    else $error("control readback differs");
  cover property (rd && i_paddr == ASP_ADDR_DATA && o_rx_interrupt);
  cover property ($rose(o_txd));
  cover property (acc && o_pslverr);
endmodule // asp_uart_chk

bind asp_uart asp_uart_chk chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_timer_edge(i_timer_edge),
  .i_rxd(i_rxd), .o_txd(o_txd), .o_tx_interrupt(o_tx_interrupt),
  .o_rx_interrupt(o_rx_interrupt));

// >>> asp_remote_port.sv
`timescale 1ns/1ps
// ****************************************************************
// Remote serial port on the far end of the line.
// ****************************************************************
module asp_remote_port #(
  parameter int BIT_CLKS = 32
) (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd,
  output logic [9:0] o_frame,
  output logic o_frame_vld
);
  initial begin
    o_rxd = 1'b1;
    o_frame = '0;
    o_frame_vld = 1'b0;
  end
  // Find the start edge, then take ten samples at bit centres, first bit into bit 0.
  always begin
    @(negedge i_txd);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      o_frame[i] = i_txd;
    end
    o_frame_vld = 1'b1;
    @(posedge i_clk);
    o_frame_vld = 1'b0;
  end
  // Send one frame, start bit in bit 0; only one stop bit is owed, the rest is idle.
  task automatic send(input logic [10:0] bits);
    for (int i = 0; i < 11; i++) begin
      o_rxd <= bits[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
    @(posedge i_clk);
  endtask
  // A short low pulse that must not be taken for a start bit.
  task automatic glitch(input int n);
    o_rxd <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_rxd <= 1'b1;
    @(posedge i_clk);
  endtask
endmodule // asp_remote_port

// >>> async_serial_port_with_baud_timer_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the serial port block.
// ****************************************************************
module async_serial_port_with_baud_timer_tb;
  import asp_pkg::*;
  localparam logic [15:0] RLD = 16'h0001;
  localparam int BIT = 32;
  logic clk, rst, psel, penable, pwrite, tedge, rxd, txd, pready, tx_int, rx_int, vld;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [63:0] ex;
  logic [9:0] frm;
  logic [63:0] exp_q[$];
  logic [9:0] frm_q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  asp_uart uut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(), .i_timer_edge(tedge), .i_rxd(rxd), .o_txd(txd),
    .o_tx_interrupt(tx_int), .o_rx_interrupt(rx_int));
  asp_remote_port #(.BIT_CLKS(BIT)) peer (.i_clk(clk), .i_txd(txd), .o_rxd(rxd),
    .o_frame(frm), .o_frame_vld(vld));
  always #50 clk = ~clk;
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One bus transfer; it holds everything until pready is seen, then idles a cycle.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e & m});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_rx();
    while (rx_int !== 1'b1) @(posedge clk);
  endtask
  task automatic pulse_edge();
    tedge <= 1'b1;
    @(posedge clk);
    tedge <= 1'b0;
    @(posedge clk);
  endtask
  // Ten bits after the start bit for format c; x flips chosen bits to break a frame.
  function automatic logic [9:0] txf(input logic [7:0] d, input logic [7:0] c,
                                     input logic [9:0] x);
    logic [9:0] f;
    f = '1;
    if (c[2]) f[7:0] = d; else f[6:0] = d[6:0];
    if (c[3]) f[c[2] ? 8 : 7] = ^(d & {c[2], 7'h7F}) ^ !c[4];
    return f ^ x;
  endfunction
  // Read data is taken at the edge that completes the access, against the oldest note.
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      ex = exp_q.pop_front();
      check(ex[31:0], prdata & ex[63:32]);
    end
  end
  always @(posedge vld) check({22'h0, frm_q.pop_front()}, {22'h0, frm});
  // A hang ends the run here; the limit is several times the expected length.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] c, d;
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; tedge = 0;
    void'($urandom(43634));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ASP_ADDR_CTRL, 32'h0, 32'hFF);
    rd(ASP_ADDR_TIMER, 32'hFFFF, 32'hFFFF);
    rd(12'h0A0, 32'h0, 32'hFFFFFFFF);
    wr(ASP_ADDR_TIMER, {16'h0, RLD});
    for (int k = 0; k < 8; k++) begin
      c = {3'b001, k[2:0], k[0] ^ k[1], 1'b1};
      d = 8'($urandom);
      wr(ASP_ADDR_CTRL, {24'h0, c});
      frm_q.push_back(txf(d, c, 10'h0));
      wr(ASP_ADDR_DATA, {24'h0, d});
      repeat (4) @(posedge clk);
      check(32'(!c[1]), 32'(tx_int));
      d = 8'($urandom);
      peer.send({txf(d, c, 10'h0), 1'b0});
      wait_rx();
      rd(ASP_ADDR_DATA, {24'h0, d & {c[2], 7'h7F}}, 32'hFF);
      while (frm_q.size() != 0) @(posedge clk);
      repeat (BIT) @(posedge clk);
      check(32'h1, 32'(tx_int));
      rd(ASP_ADDR_CTRL, {24'h0, c}, 32'hFF);
    end
    for (int e = 0; e < 3; e++) begin
      peer.send({txf(8'h5A, c, e == 0 ? 10'h100 : e == 1 ? 10'h200 : 10'h0), 1'b0});
      if (e == 2) peer.send({txf(8'hA5, c, 10'h0), 1'b0});
      wait_rx();
      rd(ASP_ADDR_CTRL, 32'h80, 32'h80);
      rd(ASP_ADDR_DATA, 32'h0, 32'h0);
      wr(ASP_ADDR_CTRL, {24'h0, c});
      rd(ASP_ADDR_CTRL, 32'h80, 32'h80);
      wr(ASP_ADDR_CTRL, {24'h0, 1'b1, c[6:0]});
      rd(ASP_ADDR_CTRL, {24'h0, c}, 32'hFF);
    end
    peer.glitch(6);
    repeat (12 * BIT) @(posedge clk);
    check(32'h0, 32'(rx_int));
    pulse_edge();
    rd(ASP_ADDR_TFLAG, 32'h0, 32'h1);
    wr(ASP_ADDR_CTRL, 32'h0);
    peer.send({txf(8'h3C, c, 10'h0), 1'b0});
    repeat (BIT) @(posedge clk);
    check(32'h0, 32'(rx_int));
    pulse_edge();
    rd(ASP_ADDR_TFLAG, 32'h1, 32'h1);
    wr(ASP_ADDR_TFLAG, 32'h0);
    rd(ASP_ADDR_TFLAG, 32'h1, 32'h1);
    wr(ASP_ADDR_TFLAG, 32'h1);
    rd(ASP_ADDR_TFLAG, 32'h0, 32'h1);
    print_verdict();
  end
endmodule // async_serial_port_with_baud_timer_tb
